/* File: common/ivc_pkg.sv */
// Constants, register map and carrier types of the interrupt vector control.
// Assumes one instruction-cycle clock and an AXI4-Lite master for software.
package ivc_pkg;

	// Register byte addresses on the AXI4-Lite bus
	localparam logic [7:0] IVC_A_CTRL = 8'h00;
	localparam logic [7:0] IVC_A_FLAG1 = 8'h04;
	localparam logic [7:0] IVC_A_FLAG2 = 8'h08;
	localparam logic [7:0] IVC_A_EN1 = 8'h0c;
	localparam logic [7:0] IVC_A_EN2 = 8'h10;
	localparam logic [7:0] IVC_A_OPT = 8'h14;
	localparam logic [7:0] IVC_A_STAT = 8'h18;
	localparam logic [7:0] IVC_A_SHADOW = 8'h20;
	localparam int IVC_SHADOW_N = 8;

	// Control register field positions
	localparam int IVC_B_GLOBAL_EN = 7;
	localparam int IVC_B_GROUP_EN = 6;
	localparam int IVC_B_TMR_EN = 5;
	localparam int IVC_B_PIN_EN = 4;
	localparam int IVC_B_CHG_EN = 3;
	localparam int IVC_B_TMR_FLAG = 2;
	localparam int IVC_B_PIN_FLAG = 1;
	localparam int IVC_B_CHG_FLAG = 0;

	// Second peripheral group has one unimplemented bit
	localparam logic [7:0] IVC_GRP2_MASK = 8'hef;
	// Core status byte mask that clears the timeout and powerdown bits
	localparam logic [7:0] IVC_STATUS_KEEP = 8'he7;
	localparam logic [7:0] IVC_RST8 = 8'h00;
	localparam logic [14:0] IVC_VECTOR = 15'h0004;
	localparam logic [1:0] IVC_RESP_OKAY = 2'b00;
	localparam logic [1:0] IVC_RESP_SLVERR = 2'b10;

	// Core context saved on entry and restored on return
	typedef struct packed {
		logic [7:0] w;
		logic [7:0] status;
		logic [7:0] bank_sel;
		logic [7:0] ptr0_lo;
		logic [7:0] ptr0_hi;
		logic [7:0] ptr1_lo;
		logic [7:0] ptr1_hi;
		logic [7:0] pc_high;
	} ivc_ctx_t;

	// Entry sequencer, Gray coded along the path
	typedef enum logic [1:0] {
		IVC_IDLE = 2'b00,
		IVC_FLUSH = 2'b01,
		IVC_VECT = 2'b11,
		IVC_SERV = 2'b10
	} ivc_state_t;

endpackage : ivc_pkg

/* File: rtl/ivc_top.sv */
// Interrupt vector control: flags, enables, entry, return, shadow context.
// Assumes the core sequencer and event sources share the clock; the
// external pin arrives asynchronously.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
module ivc_top
	import ivc_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	// AXI4-Lite slave
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Event sources
	input wire logic [7:0] periph_evt1,
	input wire logic [7:0] periph_evt2,
	input wire logic tmr0_evt,
	input wire logic ioc_any,
	input wire logic ext_pin,
	// Core sequencer
	input wire logic core_asleep,
	input wire logic core_inst_done,
	input wire logic core_ret_intr,
	input wire ivc_ctx_t live_ctx,
	output logic flush_q,
	output logic push_pc_q,
	output logic vector_load_q,
	output logic [14:0] vector_addr_q,
	output logic restore_q,
	output logic pop_pc_q,
	output ivc_ctx_t restore_ctx_q,
	output logic wake_q
);

	// ==========================================================
	// State
	// ==========================================================
	logic [7:0] ctrl_q; // Enables and core flags, bit 0 unused
	logic [7:0] flag1_q; // First peripheral flag group
	logic [7:0] flag2_q; // Second peripheral flag group
	logic [7:0] en1_q; // First peripheral enable group
	logic [7:0] en2_q; // Second peripheral enable group
	logic edge_sel_q; // One selects rising pin edge
	logic [7:0] shadow_q [IVC_SHADOW_N]; // Shadow context bytes
	ivc_state_t st_q; // Entry sequencer
	logic wait_one_q; // Wake seen, one instruction still due
	logic pin_s1_q; // Pin synchroniser first stage
	logic pin_s2_q; // Pin synchroniser second stage
	logic pin_s3_q; // Previous synchronised pin level
	logic aw_held_q; // Write address captured
	logic w_held_q; // Write data captured
	logic [7:0] awaddr_q; // Captured write address
	logic [7:0] wbyte_q; // Captured low write byte
	logic wlane_q; // Low byte lane enabled

	// ==========================================================
	// Decode and request logic
	// ==========================================================
	// Pin edge detection on the synchronised level
	wire pin_rise = pin_s2_q & ~pin_s3_q;
	wire pin_fall = ~pin_s2_q & pin_s3_q;
	wire ext_edge = edge_sel_q ? pin_rise : pin_fall;

	wire global_irq_enable = ctrl_q[IVC_B_GLOBAL_EN];
	wire peripheral_group_enable = ctrl_q[IVC_B_GROUP_EN];
	// Core sources: timer, pin, pin-change summary
	wire core_src = (ctrl_q[IVC_B_TMR_EN] & ctrl_q[IVC_B_TMR_FLAG])
		| (ctrl_q[IVC_B_PIN_EN] & ctrl_q[IVC_B_PIN_FLAG])
		| (ctrl_q[IVC_B_CHG_EN] & ioc_any);
	// Peripheral sources need the group enable as well
	wire per_src = peripheral_group_enable & ((|(flag1_q & en1_q))
		| (|(flag2_q & en2_q)));
	wire src_any = core_src | per_src;
	// Entry is held while asleep and until one instruction ran
	wire hold_entry = core_asleep | wait_one_q;
	wire take = global_irq_enable & src_any & ~hold_entry
		& (st_q == IVC_IDLE);
	wire ret_ok = core_ret_intr & (st_q == IVC_SERV);

	// Write channel decode
	wire wr_fire = aw_held_q & w_held_q & ~s_bvalid & wlane_q;
	wire wr_done = aw_held_q & w_held_q & ~s_bvalid;
	wire aw_take = s_awvalid & s_awready;
	wire w_take = s_wvalid & s_wready;
	wire ar_take = s_arvalid & s_arready;

	// True when the address selects this register, for reads and writes alike
	function automatic logic wsel(input logic [7:0] a, input logic [7:0] r);
		wsel = (a == r);
	endfunction : wsel

	// Address is inside the shadow window
	function automatic logic in_shadow(input logic [7:0] a);
		in_shadow = (a >= IVC_A_SHADOW)
			&& (a < IVC_A_SHADOW + 8'(4 * IVC_SHADOW_N))
			&& (a[1:0] == 2'b00);
	endfunction : in_shadow

	// Address is a mapped register
	function automatic logic mapped(input logic [7:0] a);
		mapped = wsel(a, IVC_A_CTRL) | wsel(a, IVC_A_FLAG1)
			| wsel(a, IVC_A_FLAG2) | wsel(a, IVC_A_EN1)
			| wsel(a, IVC_A_EN2) | wsel(a, IVC_A_OPT)
			| wsel(a, IVC_A_STAT) | in_shadow(a);
	endfunction : mapped

	wire wr_ctrl = wr_fire & wsel(awaddr_q, IVC_A_CTRL);
	wire wr_f1 = wr_fire & wsel(awaddr_q, IVC_A_FLAG1);
	wire wr_f2 = wr_fire & wsel(awaddr_q, IVC_A_FLAG2);
	wire wr_e1 = wr_fire & wsel(awaddr_q, IVC_A_EN1);
	wire wr_e2 = wr_fire & wsel(awaddr_q, IVC_A_EN2);
	wire wr_opt = wr_fire & wsel(awaddr_q, IVC_A_OPT);
	wire wr_sh = wr_fire & in_shadow(awaddr_q);
	wire [2:0] wr_sh_idx = 3'((awaddr_q - IVC_A_SHADOW) >> 2);
	wire [2:0] rd_sh_idx = 3'((s_araddr - IVC_A_SHADOW) >> 2);

	// Control register next value; hardware flag sets win
	wire [7:0] ctrl_sw = wr_ctrl ? wbyte_q : ctrl_q;
	wire [7:0] ctrl_d = {
		take ? 1'b0 : (ret_ok ? 1'b1 : ctrl_sw[7]),
		ctrl_sw[6:3],
		ctrl_sw[2] | tmr0_evt,
		ctrl_sw[1] | ext_edge,
		1'b0
	};
	wire [7:0] flag1_d = (wr_f1 ? wbyte_q : flag1_q) | periph_evt1;
	wire [7:0] flag2_d = ((wr_f2 ? wbyte_q : flag2_q) | periph_evt2)
		& IVC_GRP2_MASK;

	// Read view; summary flag follows the pin-change sources
	wire [7:0] ctrl_rd = {ctrl_q[7:1], ioc_any};
	wire [7:0] stat_rd = {4'h0, wait_one_q, src_any, st_q};
	wire [7:0] rd_byte =
		wsel(s_araddr, IVC_A_CTRL) ? ctrl_rd :
		wsel(s_araddr, IVC_A_FLAG1) ? flag1_q :
		wsel(s_araddr, IVC_A_FLAG2) ? flag2_q :
		wsel(s_araddr, IVC_A_EN1) ? en1_q :
		wsel(s_araddr, IVC_A_EN2) ? en2_q :
		wsel(s_araddr, IVC_A_OPT) ? {7'h00, edge_sel_q} :
		wsel(s_araddr, IVC_A_STAT) ? stat_rd :
		in_shadow(s_araddr) ? shadow_q[rd_sh_idx] : 8'h00;

	// Live context with timeout and powerdown left out
	wire [63:0] live_flat = live_ctx;
	wire [7:0] live_status = live_ctx.status & IVC_STATUS_KEEP;

	// Gathered shadow context for restore
	ivc_ctx_t shadow_ctx;
	assign shadow_ctx = {shadow_q[0], shadow_q[1], shadow_q[2],
		shadow_q[3], shadow_q[4], shadow_q[5], shadow_q[6],
		shadow_q[7]};

	// ==========================================================
	// Pin synchroniser, sampled every instruction cycle
	// ==========================================================
	// Runs through reset so all stages settle to the pin level and no
	// false edge follows reset, whatever level the pin idles at.
	always_ff @(posedge clock) begin
		pin_s1_q <= ext_pin;
		pin_s2_q <= pin_s1_q;
		pin_s3_q <= pin_s2_q;
	end

	// ==========================================================
	// Control, flag and enable registers
	// ==========================================================
	always_ff @(posedge clock) begin
		if (!nrst) begin
			ctrl_q <= IVC_RST8;
			flag1_q <= IVC_RST8;
			flag2_q <= IVC_RST8;
			en1_q <= IVC_RST8;
			en2_q <= IVC_RST8;
			edge_sel_q <= 1'b1;
		end else begin
			ctrl_q <= ctrl_d;
			flag1_q <= flag1_d;
			flag2_q <= flag2_d;
			if (wr_e1) begin
				en1_q <= wbyte_q;
			end
			if (wr_e2) begin
				en2_q <= wbyte_q & IVC_GRP2_MASK;
			end
			if (wr_opt) begin
				edge_sel_q <= wbyte_q[0];
			end
		end
	end

	// ==========================================================
	// Shadow context: saved on entry, software may edit
	// ==========================================================
	always_ff @(posedge clock) begin
		if (!nrst) begin
			for (int i = 0; i < IVC_SHADOW_N; i++) begin
				shadow_q[i] <= IVC_RST8;
			end
		end else if (take) begin
			for (int i = 0; i < IVC_SHADOW_N; i++) begin
				shadow_q[i] <= live_flat[63 - 8 * i -: 8];
			end
			shadow_q[1] <= live_status;
		end else if (wr_sh) begin
			shadow_q[wr_sh_idx] <= wbyte_q;
		end
	end

	// ==========================================================
	// Entry sequencer and core strobes
	// ==========================================================
	// Entry waits for an instruction boundary only after a wake, so one- and
	// two-cycle instructions see the same latency.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			st_q <= IVC_IDLE;
			flush_q <= 1'b0;
			push_pc_q <= 1'b0;
			vector_load_q <= 1'b0;
			vector_addr_q <= 15'h0000;
			restore_q <= 1'b0;
			pop_pc_q <= 1'b0;
			restore_ctx_q <= '0;
		end else begin
			flush_q <= take;
			push_pc_q <= take;
			vector_load_q <= (st_q == IVC_FLUSH);
			restore_q <= ret_ok;
			pop_pc_q <= ret_ok;
			if (st_q == IVC_FLUSH) begin
				vector_addr_q <= IVC_VECTOR;
			end
			if (ret_ok) begin
				restore_ctx_q <= shadow_ctx;
			end
			case (st_q)
				IVC_IDLE: begin
					if (take) begin
						st_q <= IVC_FLUSH;
					end
				end
				IVC_FLUSH: begin
					st_q <= IVC_VECT;
				end
				IVC_VECT: begin
					st_q <= IVC_SERV;
				end
				IVC_SERV: begin
					if (ret_ok) begin
						st_q <= IVC_IDLE;
					end
				end
				default: begin
					st_q <= IVC_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Wake from sleep: enabled source wakes even with global clear
	// ==========================================================
	always_ff @(posedge clock) begin
		if (!nrst) begin
			wake_q <= 1'b0;
			wait_one_q <= 1'b0;
		end else begin
			wake_q <= core_asleep & src_any;
			if (core_asleep & src_any) begin
				wait_one_q <= 1'b1;
			end else if (core_inst_done) begin
				wait_one_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite slave
	// ==========================================================
	always_ff @(posedge clock) begin
		if (!nrst) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h00;
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= IVC_RESP_OKAY;
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= IVC_RESP_OKAY;
		end else begin
			// Address and data are taken in either order
			if (aw_take) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_awaddr;
			end else if (wr_done) begin
				aw_held_q <= 1'b0;
			end
			if (w_take) begin
				w_held_q <= 1'b1;
				wbyte_q <= s_wdata[7:0];
				wlane_q <= s_wstrb[0];
			end else if (wr_done) begin
				w_held_q <= 1'b0;
			end
			s_awready <= ~aw_held_q & ~aw_take & ~s_bvalid & ~wr_done;
			s_wready <= ~w_held_q & ~w_take & ~s_bvalid & ~wr_done;
			// Response once both halves are in
			if (wr_done) begin
				s_bvalid <= 1'b1;
				s_bresp <= mapped(awaddr_q) ? IVC_RESP_OKAY : IVC_RESP_SLVERR;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
			// Read answered the cycle after the address is taken
			if (ar_take) begin
				s_rvalid <= 1'b1;
				s_rdata <= {24'h000000, rd_byte};
				s_rresp <= mapped(s_araddr) ? IVC_RESP_OKAY : IVC_RESP_SLVERR;
			end else if (s_rready) begin
				s_rvalid <= 1'b0;
			end
			// Ready never waits for valid to drop, so a held request
			// is taken once the previous answer has gone.
			s_arready <= ~s_rvalid & ~ar_take;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	reset_clears_en_a: assert property (@(posedge clock)
		disable iff (!nrst) $rose(nrst) |-> !global_irq_enable
		&& en1_q == 8'h00)
		else $error("enables not cleared by reset");

	entry_needs_en_a: assert property (@(posedge clock)
		disable iff (!nrst) $rose(flush_q) |-> $past(global_irq_enable)
		&& $past(src_any))
		else $error("entry without enables");

	flag_sticky_a: assert property (@(posedge clock)
		disable iff (!nrst) periph_evt1[0] |=> flag1_q[0])
		else $error("flag not set by event");

	flag_hold_a: assert property (@(posedge clock)
		disable iff (!nrst) flag1_q[0] && !wr_f1 |=> flag1_q[0])
		else $error("flag lost without software clear");

	vector_seq_a: assert property (@(posedge clock)
		disable iff (!nrst) flush_q |-> !global_irq_enable ##1
		(vector_load_q && vector_addr_q == IVC_VECTOR))
		else $error("vector not loaded after flush");

	return_restore_a: assert property (@(posedge clock)
		disable iff (!nrst) ret_ok |=> restore_q && pop_pc_q
		&& global_irq_enable)
		else $error("return did not restore");

	sync_latency_a: assert property (@(posedge clock)
		disable iff (!nrst) (tmr0_evt && ctrl_q[IVC_B_TMR_EN]
		&& global_irq_enable
		&& st_q == IVC_IDLE && !hold_entry && !core_asleep
		&& !wr_fire) |-> ##[2:3] vector_load_q)
		else $error("synchronous latency out of range");

	pin_edge_flag_a: assert property (@(posedge clock)
		disable iff (!nrst) ext_edge |=> ctrl_q[IVC_B_PIN_FLAG])
		else $error("pin edge did not set flag");

	wake_defers_a: assert property (@(posedge clock)
		disable iff (!nrst) (wake_q && core_asleep == 1'b0
		&& !core_inst_done) |-> !take)
		else $error("vector taken before instruction after wake");

endmodule : ivc_top

/* File: verification/ivc_core_model.sv */
// Behavioural core sequencer that faces the interrupt vector control.
// Assumes the bench pulses ret_req and sleep_req for one cycle each.
module ivc_core_model
	import ivc_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic ret_req,
	input wire logic sleep_req,
	input wire logic wake_q,
	output logic core_asleep,
	output logic core_inst_done,
	output logic core_ret_intr,
	output ivc_ctx_t live_ctx
);
	timeunit 1ns;
	timeprecision 100ps;

	// =====
	// Live context
	// Fixed context; status has timeout and powerdown set to show masking
	assign live_ctx = ivc_ctx_t'(64'h3cff_1f12_3456_780e);

	// =====
	// Sleep, retire and return strobes
	// Registered like a real sequencer, so no answer is instant
	always_ff @(posedge clock) begin
		if (!nrst) begin
			core_asleep <= 1'b0;
			core_inst_done <= 1'b0;
			core_ret_intr <= 1'b0;
		end else begin
			// Sleep entered on request, left only on wake
			if (sleep_req)
				core_asleep <= 1'b1;
			else if (wake_q)
				core_asleep <= 1'b0;
			// Next instruction retires first after wake
			core_inst_done <= !core_asleep && !sleep_req;
			// Return instruction issued on request
			core_ret_intr <= ret_req;
		end
	end
endmodule : ivc_core_model

/* File: verification/tb_ivc_top.sv */
// Self-checking bench of the interrupt vector control.
// Assumes the package and the core model are compiled before it.
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
	n_errors++; $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_ivc_top
	import ivc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, nrst;
	logic [7:0] s_awaddr, s_araddr, periph_evt1, periph_evt2;
	logic [31:0] s_wdata, s_rdata;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp, r;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready;
	logic tmr0_evt, ioc_any, ext_pin, core_asleep, core_inst_done;
	logic core_ret_intr;
	logic flush_q, push_pc_q, vector_load_q, restore_q, pop_pc_q, wake_q;
	logic [14:0] vector_addr_q;
	logic ret_req, sleep_req;
	ivc_ctx_t live_ctx, restore_ctx_q;
	int n_errors, comparisons, n_flush;

	// =====
	// Design and core model
	ivc_top u_ivc_top (.clock, .nrst, .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
		.s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
		.s_rvalid, .s_rready, .periph_evt1, .periph_evt2, .tmr0_evt,
		.ioc_any, .ext_pin, .core_asleep, .core_inst_done, .core_ret_intr,
		.live_ctx, .flush_q, .push_pc_q, .vector_load_q, .vector_addr_q,
		.restore_q, .pop_pc_q, .restore_ctx_q, .wake_q);
	ivc_core_model u_ivc_core_model (.clock, .nrst, .ret_req, .sleep_req,
		.wake_q, .core_asleep, .core_inst_done, .core_ret_intr, .live_ctx);

	// =====
	// Clock, entry counter and watchdog
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Counts entries so that refused entries show up later
	always @(posedge clock) begin
		if (flush_q === 1'b1)
			n_flush++;
	end
	// Run needs well under a thousand cycles
	initial begin
		#(3000 * 50);
		n_errors++;
		close_out;
	end

	// =====
	// Bus tasks
	// Write one register; address and data offered together
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		s_awaddr <= a;
		s_wdata <= {24'h0, v};
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge clock);
			// Each channel released at its own handshake
			if (s_awready && !aw) begin
				aw = 1'b1;
				s_awvalid <= 1'b0;
			end
			if (s_wready && !w) begin
				w = 1'b1;
				s_wvalid <= 1'b0;
			end
		end while (s_bvalid !== 1'b1);
		// Response ready stays up between writes
		r = s_bresp;
	endtask : wr

	// Read one register and compare its word
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_arready)
				s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1);
		// Read ready stays up between reads
		r = s_rresp;
		`CHK(nm, e, s_rdata)
	endtask : rchk

	// =====
	// Core and event tasks
	// Timer event high at exactly one sampling edge
	task automatic evt_tmr;
		tmr0_evt <= 1'b1;
		@(posedge clock);
		tmr0_evt <= 1'b0;
	endtask : evt_tmr

	// Return from service and check the restore strobes
	task automatic ret(input logic [7:0] w);
		ret_req <= 1'b1;
		@(posedge clock);
		ret_req <= 1'b0;
		@(posedge clock);
		@(negedge clock);
		`CHK("restore", 1'b1, restore_q)
		`CHK("pop", 1'b1, pop_pc_q)
		`CHK("ctx_w", w, restore_ctx_q.w)
		@(posedge clock);
	endtask : ret

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// =====
	// Test sequence
	initial begin
		nrst = 1'b0;
		{s_awaddr, s_araddr, s_wdata} = '0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		s_wstrb = 4'hf;
		{periph_evt1, periph_evt2, tmr0_evt, ioc_any, ext_pin} = '0;
		{ret_req, sleep_req} = '0;
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		// Reset values and an unmapped place
		rchk("ctrl", IVC_A_CTRL, 32'h0);
		rchk("en1", IVC_A_EN1, 32'h0);
		rchk("edge", IVC_A_OPT, 32'h1);
		rchk("unmapped", 8'h40, 32'h0);
		`CHK("rresp", IVC_RESP_SLVERR, r)
		$display("test reset done");
		// Flags set with every enable clear, no entry
		evt_tmr;
		periph_evt2 <= 8'hff;
		@(posedge clock);
		periph_evt2 <= 8'h00;
		repeat (3) @(posedge clock);
		rchk("ctrl", IVC_A_CTRL, 32'h04);
		rchk("flag2", IVC_A_FLAG2, {24'h0, IVC_GRP2_MASK});
		`CHK("entries", 0, n_flush)
		$display("test flags done");
		// Entry latency, vector and saved context
		wr(IVC_A_CTRL, 8'ha0);
		`CHK("bresp", IVC_RESP_OKAY, r)
		evt_tmr;
		@(posedge clock);
		@(negedge clock);
		`CHK("flush", 1'b1, flush_q)
		`CHK("push", 1'b1, push_pc_q)
		@(negedge clock);
		`CHK("vload", 1'b1, vector_load_q)
		`CHK("vaddr", IVC_VECTOR, vector_addr_q)
		@(posedge clock);
		rchk("ctrl", IVC_A_CTRL, 32'h24);
		rchk("sh_w", IVC_A_SHADOW, 32'h3c);
		rchk("sh_st", IVC_A_SHADOW + 8'h04, 32'he7);
		$display("test entry done");
		// Shadow edit applied on return, global enable back
		wr(IVC_A_SHADOW, 8'h5a);
		rchk("sh_w2", IVC_A_SHADOW, 32'h5a);
		rchk("poll", IVC_A_CTRL, 32'h24);
		wr(IVC_A_CTRL, 8'h20);
		ret(8'h5a);
		rchk("ctrl", IVC_A_CTRL, 32'ha0);
		$display("test return done");
		// Peripheral source needs the group enable
		wr(IVC_A_EN1, 8'h01);
		periph_evt1 <= 8'h01;
		@(posedge clock);
		periph_evt1 <= 8'h00;
		repeat (6) @(posedge clock);
		`CHK("entries", 1, n_flush)
		rchk("flag1", IVC_A_FLAG1, 32'h01);
		wr(IVC_A_CTRL, 8'he0);
		repeat (4) @(posedge clock);
		`CHK("entries", 2, n_flush)
		wr(IVC_A_FLAG1, 8'h00);
		ret(8'h3c);
		$display("test group done");
		// Pin edge select, then read-only summary flag
		wr(IVC_A_CTRL, 8'h00);
		wr(IVC_A_OPT, 8'h00);
		ext_pin <= 1'b1;
		repeat (6) @(posedge clock);
		rchk("rise", IVC_A_CTRL, 32'h00);
		ext_pin <= 1'b0;
		repeat (6) @(posedge clock);
		rchk("fall", IVC_A_CTRL, 32'h02);
		ioc_any <= 1'b1;
		wr(IVC_A_CTRL, 8'h00);
		rchk("ioc", IVC_A_CTRL, 32'h01);
		ioc_any <= 1'b0;
		$display("test pin done");
		// Wake with the global enable clear: resume, no entry
		wr(IVC_A_CTRL, 8'h20);
		sleep_req <= 1'b1;
		@(posedge clock);
		sleep_req <= 1'b0;
		repeat (2) @(posedge clock);
		evt_tmr;
		repeat (4) @(posedge clock);
		`CHK("awake", 1'b0, core_asleep)
		`CHK("entries", 2, n_flush)
		$display("test wake done");
		// Wake with the global enable set: one instruction, then vector
		wr(IVC_A_CTRL, 8'ha0);
		sleep_req <= 1'b1;
		@(posedge clock);
		sleep_req <= 1'b0;
		repeat (2) @(posedge clock);
		evt_tmr;
		repeat (2) @(posedge clock);
		`CHK("early", 2, n_flush)
		repeat (6) @(posedge clock);
		`CHK("entries", 3, n_flush)
		$display("test wake vector done");
		close_out;
	end
endmodule : tb_ivc_top
